// File: inc/swcmd_pkg.sv
// Constants, field positions and types for the settings write command handler
package swcmd_pkg;
  // Command codes, least significant byte received first
  localparam logic [31:0] CODE_STAGE_LABEL = 32'h656d6e73;
  localparam logic [31:0] CODE_UNIT_LABEL  = 32'h666d6e73;
  localparam logic [31:0] CODE_USER_WORDS  = 32'h6d766e73;
  localparam logic [31:0] CODE_PID         = 32'h64697073;
  localparam logic [31:0] CODE_SECRET      = 32'h64777073;
  localparam logic [31:0] CODE_POWER       = 32'h72777073;
  // Request lengths in bytes
  localparam logic [5:0] LEN_LABEL = 6'h1e;
  localparam logic [5:0] LEN_USER  = 6'h24;
  localparam logic [5:0] LEN_PID   = 6'h30;
  localparam logic [5:0] LEN_POWER = 6'h14;
  localparam int         BUF_BYTES = 48;
  localparam logic [5:0] BODY_START = 6'h04;
  // Byte positions inside a request
  localparam int POS_BODY       = 4;
  localparam int POS_FLAGS      = 20;
  localparam int LABEL_BYTES    = 16;
  localparam int USER_WORDS     = 7;
  localparam int SECRET_BYTES   = 20;
  localparam int POS_HOLD       = 4;
  localparam int POS_RED_DELAY  = 5;
  localparam int POS_OFF_DELAY  = 7;
  localparam int POS_RAMP       = 9;
  localparam int POS_PWR_FLAGS  = 11;
  localparam int POS_KP         = 4;
  localparam int POS_KI         = 6;
  localparam int POS_KD         = 8;
  localparam int POS_KPF        = 10;
  localparam int POS_KIF        = 14;
  localparam int POS_KDF        = 18;
  // Flag bits
  localparam int BIT_EXT_OVERRIDE = 0;
  localparam int BIT_REDUCTION_ON = 0;
  localparam int BIT_SHUTOFF_ON   = 1;
  localparam int BIT_SMOOTH_RAMP  = 2;
  // Current in percent of nominal
  localparam logic [7:0] PCT_NOMINAL = 8'h64;
  localparam logic [7:0] PCT_STEP    = 8'h01;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1000000;
  localparam int MS_PER_S      = 1000;
  localparam int PCT_PER_FULL  = 100;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_POWER    = 8'h08;
  localparam logic [7:0] ADDR_DELAYS   = 8'h0c;
  localparam logic [7:0] ADDR_RAMP     = 8'h10;
  localparam logic [7:0] ADDR_FLAGS    = 8'h14;
  localparam logic [7:0] ADDR_VGAIN_PI = 8'h18;
  localparam logic [7:0] ADDR_VGAIN_D  = 8'h1c;
  localparam logic [7:0] ADDR_FGAIN    = 8'h20;
  localparam logic [7:0] ADDR_STAGE    = 8'h40;
  localparam logic [7:0] ADDR_UNIT     = 8'h50;
  localparam logic [7:0] ADDR_USER     = 8'h60;
  localparam logic [7:0] ADDR_SECRET   = 8'h80;
  localparam logic [7:0] ADDR_END      = 8'h94;
  localparam logic [31:0] CTRL_RESET   = 32'h00000001;
  typedef enum logic [2:0] {
    SWCMD_RX_IDLE    = 3'b001,
    SWCMD_RX_COLLECT = 3'b010,
    SWCMD_RX_SKIP    = 3'b100
  } swcmd_rx_e;
  typedef enum logic [1:0] {
    SWCMD_TX_IDLE = 2'b01,
    SWCMD_TX_SEND = 2'b10
  } swcmd_tx_e;
endpackage : swcmd_pkg

// File: core/swcmd_top.sv
// Settings write command handler with APB register access and power sequencer
//
// Added by the designer: the APB interface to the registers and the placing of the registers.

// How it works
// - A 30-byte request with code 0x656d6e73 stores a 16-character stage label for the EEPROM.
// - A 30-byte request with code 0x666d6e73 stores a 16-character unit label and a flag byte.
// - Flag bit 0x1 of the unit flag byte makes external store settings override local ones.
// - A 36-byte request with code 0x6d766e73 stores user words for the FRAM.
// - Each user word is taken as exactly 32 bits.
// - A 48-byte request with code 0x64697073 carries three 16-bit and three float PID gains.
// - Received PID gains are kept in working registers that are only read back over APB.
// - A 36-byte request with code 0x64777073 sets the web password string.
// - A 20-byte request with code 0x72777073 carries hold current, three times and flags.
// - The hold current is a percentage of nominal, valid from 0 to 100.
// - With flag 0x1 the current drops to hold level, complete the set ms after stopping.
// - With flag 0x2 motor power goes off the set seconds after stopping.
// - With flag 0x4 current changes ramp smoothly over the set ramp time in ms.
module swcmd_top #(
  parameter int MS_CYCLES = swcmd_pkg::MS_NS / swcmd_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Command link from the host, one byte per valid cycle
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // Answer to the host
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // Motor side
  input  wire logic        stop_state,
  output logic [7:0]       current_pct,
  output logic             motor_power_on,
  output logic             external_store_overrides,
  output logic             eeprom_write,
  output logic             fram_write
);
  localparam int PCT_CYCLES = MS_CYCLES / swcmd_pkg::PCT_PER_FULL;

  typedef struct packed {
    swcmd_pkg::swcmd_rx_e          rx_st;
    swcmd_pkg::swcmd_tx_e          tx_st;
    logic [swcmd_pkg::BUF_BYTES-1:0][7:0] buffer;
    logic [5:0]                    count;
    logic [15:0]                   sum;
    logic [7:0]                    prev;
    logic [31:0]                   answer;
    logic [1:0]                    tx_idx;
    logic [15:0][7:0]              stage_label;
    logic [15:0][7:0]              unit_label;
    logic [7:0]                    internal_flags;
    logic [6:0][31:0]              user_words;
    logic [15:0]                   volt_prop_gain;
    logic [15:0]                   volt_integ_gain;
    logic [15:0]                   volt_diff_gain;
    logic [2:0][31:0]              float_gain;
    logic [19:0][7:0]              web_secret;
    logic [7:0]                    idle_current_pct;
    logic [15:0]                   reduction_delay_ms;
    logic [15:0]                   shutoff_delay_s;
    logic [15:0]                   current_ramp_ms;
    logic [7:0]                    power_ctl_flags;
    logic [31:0]                   ctrl;
    logic [15:0]                   accepted;
    logic [15:0]                   rejected;
    logic                          stopped;
    logic [31:0]                   ms_div;
    logic [15:0]                   elapsed_ms;
    logic [9:0]                    sec_div;
    logic [15:0]                   elapsed_s;
    logic [31:0]                   ramp_div;
    logic [7:0]                    current;
    logic                          power_on;
    logic                          eeprom_wr;
    logic                          fram_wr;
    logic                          pready;
    logic [31:0]                   prdata;
    logic                          pslverr;
  } swcmd_state_s;

  swcmd_state_s st_reg;
  swcmd_state_s st_next;

  function automatic logic [15:0] swcmd_get16(
    input logic [swcmd_pkg::BUF_BYTES-1:0][7:0] b,
    input int                                   pos
  );
    swcmd_get16 = {b[pos+1], b[pos]};
  endfunction : swcmd_get16

  function automatic logic [31:0] swcmd_get32(
    input logic [swcmd_pkg::BUF_BYTES-1:0][7:0] b,
    input int                                   pos
  );
    swcmd_get32 = {b[pos+3], b[pos+2], b[pos+1], b[pos]};
  endfunction : swcmd_get32

  logic [31:0] code;
  logic        len_ok;
  logic [15:0] payload_sum;
  logic [15:0] frame_crc;
  logic        frame_ok;
  logic [7:0]  hold_pct;
  logic [7:0]  target;
  logic        smooth;
  logic        reduce_due;
  logic        ramp_tick;
  logic [31:0] ramp_span;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [5:0]  byte_count;
  logic [16:0] reduce_sum;

  // Register read mux
  always_comb begin
    rd_hit   = 1'b1;
    rd_word  = '0;
    case (paddr)
      swcmd_pkg::ADDR_CTRL:     rd_word = st_reg.ctrl;
      swcmd_pkg::ADDR_STATUS:   rd_word = {st_reg.accepted[7:0], st_reg.rejected[7:0],
                                           st_reg.current, 5'h00, st_reg.stopped,
                                           st_reg.power_on, st_reg.rx_st != swcmd_pkg::SWCMD_RX_IDLE};
      swcmd_pkg::ADDR_POWER:    rd_word = {16'h0000, st_reg.power_ctl_flags, st_reg.idle_current_pct};
      swcmd_pkg::ADDR_DELAYS:   rd_word = {st_reg.shutoff_delay_s, st_reg.reduction_delay_ms};
      swcmd_pkg::ADDR_RAMP:     rd_word = {16'h0000, st_reg.current_ramp_ms};
      swcmd_pkg::ADDR_FLAGS:    rd_word = {24'h000000, st_reg.internal_flags};
      swcmd_pkg::ADDR_VGAIN_PI: rd_word = {st_reg.volt_integ_gain, st_reg.volt_prop_gain};
      swcmd_pkg::ADDR_VGAIN_D:  rd_word = {16'h0000, st_reg.volt_diff_gain};
      default: begin
        if (paddr[1:0] != 2'h0 || paddr >= swcmd_pkg::ADDR_END) begin
          rd_hit = 1'b0;
        end else if (paddr >= swcmd_pkg::ADDR_SECRET) begin
          rd_word = st_reg.web_secret[32'(paddr - swcmd_pkg::ADDR_SECRET) +: 4];
        end else if (paddr >= swcmd_pkg::ADDR_USER) begin
          rd_word = st_reg.user_words[(paddr - swcmd_pkg::ADDR_USER) >> 2];
        end else if (paddr >= swcmd_pkg::ADDR_UNIT) begin
          rd_word = st_reg.unit_label[32'(paddr - swcmd_pkg::ADDR_UNIT) +: 4];
        end else if (paddr >= swcmd_pkg::ADDR_STAGE) begin
          rd_word = st_reg.stage_label[32'(paddr - swcmd_pkg::ADDR_STAGE) +: 4];
        end else if (paddr >= swcmd_pkg::ADDR_FGAIN && paddr < swcmd_pkg::ADDR_FGAIN + 8'h0c) begin
          rd_word = st_reg.float_gain[(paddr - swcmd_pkg::ADDR_FGAIN) >> 2];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Frame checks at the last byte
  always_comb begin
    code        = swcmd_get32(st_reg.buffer, 0);
    byte_count  = st_reg.count + 6'h01;
    payload_sum = st_reg.sum - {8'h00, st_reg.prev};
    frame_crc   = {rx_data, st_reg.prev};
    case (code)
      swcmd_pkg::CODE_STAGE_LABEL, swcmd_pkg::CODE_UNIT_LABEL:
        len_ok = byte_count == swcmd_pkg::LEN_LABEL;
      swcmd_pkg::CODE_USER_WORDS, swcmd_pkg::CODE_SECRET:
        len_ok = byte_count == swcmd_pkg::LEN_USER;
      swcmd_pkg::CODE_PID:
        len_ok = byte_count == swcmd_pkg::LEN_PID;
      swcmd_pkg::CODE_POWER:
        len_ok = byte_count == swcmd_pkg::LEN_POWER;
      default:
        len_ok = 1'b0;
    endcase
    frame_ok = len_ok && payload_sum == frame_crc;
  end

  // Power sequencing terms
  always_comb begin
    hold_pct   = (st_reg.idle_current_pct > swcmd_pkg::PCT_NOMINAL) ?
                 swcmd_pkg::PCT_NOMINAL : st_reg.idle_current_pct;
    smooth     = st_reg.power_ctl_flags[swcmd_pkg::BIT_SMOOTH_RAMP];
    reduce_sum = {1'b0, st_reg.elapsed_ms} + (smooth ? {1'b0, st_reg.current_ramp_ms} : 17'h00000);
    reduce_due = reduce_sum >= {1'b0, st_reg.reduction_delay_ms};
    target     = (st_reg.stopped && st_reg.power_ctl_flags[swcmd_pkg::BIT_REDUCTION_ON] &&
                  reduce_due) ? hold_pct : swcmd_pkg::PCT_NOMINAL;
    ramp_span  = 32'(st_reg.current_ramp_ms) * 32'(PCT_CYCLES);
    ramp_tick  = st_reg.ramp_div + 32'h00000001 >= ramp_span;
  end

  always_comb begin
    st_next           = st_reg;
    st_next.eeprom_wr = 1'b0;
    st_next.fram_wr   = 1'b0;
    // APB slave, one wait cycle per access
    st_next.pready  = psel && penable && !st_reg.pready;
    st_next.pslverr = psel && penable && !st_reg.pready && !rd_hit;
    st_next.prdata  = (psel && penable && !st_reg.pready && !pwrite) ? rd_word : '0;
    if (psel && penable && !st_reg.pready && pwrite && paddr == swcmd_pkg::ADDR_CTRL) begin
      st_next.ctrl = pwdata;
    end
    // Request reception
    case (st_reg.rx_st)
      swcmd_pkg::SWCMD_RX_IDLE: begin
        if (rx_valid) begin
          st_next.buffer[0] = rx_data;
          st_next.count     = 6'h01;
          st_next.sum       = '0;
          st_next.rx_st     = (!st_reg.ctrl[0] || rx_last) ? swcmd_pkg::SWCMD_RX_SKIP :
                              swcmd_pkg::SWCMD_RX_COLLECT;
          if (rx_last) begin
            st_next.rx_st    = swcmd_pkg::SWCMD_RX_IDLE;
            st_next.rejected = st_reg.rejected + 16'h0001;
          end
        end
      end
      swcmd_pkg::SWCMD_RX_COLLECT: begin
        if (rx_valid) begin
          st_next.buffer[st_reg.count] = rx_data;
          st_next.count = byte_count;
          st_next.prev  = rx_data;
          if (st_reg.count >= swcmd_pkg::BODY_START) begin
            st_next.sum = st_reg.sum + {8'h00, rx_data};
          end
          if (rx_last) begin
            st_next.rx_st = swcmd_pkg::SWCMD_RX_IDLE;
            if (frame_ok) begin
              st_next.accepted = st_reg.accepted + 16'h0001;
              st_next.answer   = code;
              st_next.tx_idx   = 2'h0;
              st_next.tx_st    = swcmd_pkg::SWCMD_TX_SEND;
              case (code)
                swcmd_pkg::CODE_STAGE_LABEL: begin
                  st_next.stage_label = st_reg.buffer[swcmd_pkg::POS_BODY +: swcmd_pkg::LABEL_BYTES];
                  st_next.eeprom_wr   = 1'b1;
                end
                swcmd_pkg::CODE_UNIT_LABEL: begin
                  st_next.unit_label     = st_reg.buffer[swcmd_pkg::POS_BODY +: swcmd_pkg::LABEL_BYTES];
                  st_next.internal_flags = st_reg.buffer[swcmd_pkg::POS_FLAGS];
                  st_next.fram_wr        = 1'b1;
                end
                swcmd_pkg::CODE_USER_WORDS: begin
                  for (int i = 0; i < swcmd_pkg::USER_WORDS; i++) begin
                    st_next.user_words[i] = swcmd_get32(st_reg.buffer, swcmd_pkg::POS_BODY + 4 * i);
                  end
                  st_next.fram_wr = 1'b1;
                end
                swcmd_pkg::CODE_PID: begin
                  st_next.volt_prop_gain  = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_KP);
                  st_next.volt_integ_gain = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_KI);
                  st_next.volt_diff_gain  = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_KD);
                  st_next.float_gain[0]   = swcmd_get32(st_reg.buffer, swcmd_pkg::POS_KPF);
                  st_next.float_gain[1]   = swcmd_get32(st_reg.buffer, swcmd_pkg::POS_KIF);
                  st_next.float_gain[2]   = swcmd_get32(st_reg.buffer, swcmd_pkg::POS_KDF);
                end
                swcmd_pkg::CODE_SECRET: begin
                  st_next.web_secret = st_reg.buffer[swcmd_pkg::POS_BODY +: swcmd_pkg::SECRET_BYTES];
                end
                swcmd_pkg::CODE_POWER: begin
                  st_next.idle_current_pct   = st_reg.buffer[swcmd_pkg::POS_HOLD];
                  st_next.reduction_delay_ms = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_RED_DELAY);
                  st_next.shutoff_delay_s    = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_OFF_DELAY);
                  st_next.current_ramp_ms    = swcmd_get16(st_reg.buffer, swcmd_pkg::POS_RAMP);
                  st_next.power_ctl_flags    = st_reg.buffer[swcmd_pkg::POS_PWR_FLAGS];
                end
                default: begin
                  st_next.answer = code;
                end
              endcase
            end else begin
              st_next.rejected = st_reg.rejected + 16'h0001;
            end
          end else if (byte_count == 6'(swcmd_pkg::BUF_BYTES)) begin
            st_next.rx_st = swcmd_pkg::SWCMD_RX_SKIP;
          end
        end
      end
      swcmd_pkg::SWCMD_RX_SKIP: begin
        if (rx_valid && rx_last) begin
          st_next.rx_st    = swcmd_pkg::SWCMD_RX_IDLE;
          st_next.rejected = st_reg.rejected + 16'h0001;
        end
      end
      default: st_next.rx_st = swcmd_pkg::SWCMD_RX_IDLE;
    endcase
    // Answer bytes, least significant first
    case (st_reg.tx_st)
      swcmd_pkg::SWCMD_TX_IDLE: ;
      swcmd_pkg::SWCMD_TX_SEND: begin
        if (tx_ready && st_next.tx_st == swcmd_pkg::SWCMD_TX_SEND && st_next.tx_idx == st_reg.tx_idx) begin
          st_next.tx_idx = st_reg.tx_idx + 2'h1;
          if (st_reg.tx_idx == 2'h3) begin
            st_next.tx_st = swcmd_pkg::SWCMD_TX_IDLE;
          end
        end
      end
      default: st_next.tx_st = swcmd_pkg::SWCMD_TX_IDLE;
    endcase
    // Stop state timers
    st_next.stopped = stop_state;
    if (!stop_state || !st_reg.stopped) begin
      st_next.ms_div     = '0;
      st_next.elapsed_ms = '0;
      st_next.sec_div    = '0;
      st_next.elapsed_s  = '0;
    end else if (st_reg.ms_div == 32'(MS_CYCLES - 1)) begin
      st_next.ms_div = '0;
      if (st_reg.elapsed_ms != 16'hffff) begin
        st_next.elapsed_ms = st_reg.elapsed_ms + 16'h0001;
      end
      if (st_reg.sec_div == 10'(swcmd_pkg::MS_PER_S - 1)) begin
        st_next.sec_div = '0;
        if (st_reg.elapsed_s != 16'hffff) begin
          st_next.elapsed_s = st_reg.elapsed_s + 16'h0001;
        end
      end else begin
        st_next.sec_div = st_reg.sec_div + 10'h001;
      end
    end else begin
      st_next.ms_div = st_reg.ms_div + 32'h00000001;
    end
    // Winding current toward its target
    st_next.ramp_div = (ramp_tick || st_reg.current == target) ? '0 :
                       st_reg.ramp_div + 32'h00000001;
    if (!smooth) begin
      st_next.current = target;
    end else if (ramp_tick && st_reg.current < target) begin
      st_next.current = st_reg.current + swcmd_pkg::PCT_STEP;
    end else if (ramp_tick && st_reg.current > target) begin
      st_next.current = st_reg.current - swcmd_pkg::PCT_STEP;
    end
    st_next.power_on = !(st_reg.stopped && st_reg.power_ctl_flags[swcmd_pkg::BIT_SHUTOFF_ON] &&
                         st_reg.elapsed_s >= st_reg.shutoff_delay_s);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.rx_st    <= swcmd_pkg::SWCMD_RX_IDLE;
      st_reg.tx_st    <= swcmd_pkg::SWCMD_TX_IDLE;
      st_reg.ctrl     <= swcmd_pkg::CTRL_RESET;
      st_reg.current  <= swcmd_pkg::PCT_NOMINAL;
      st_reg.power_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready                   = st_reg.pready;
  assign prdata                   = st_reg.prdata;
  assign pslverr                  = st_reg.pslverr;
  assign tx_valid                 = st_reg.tx_st == swcmd_pkg::SWCMD_TX_SEND;
  assign tx_data                  = st_reg.answer[8*st_reg.tx_idx +: 8];
  assign current_pct              = st_reg.current;
  assign motor_power_on           = st_reg.power_on;
  assign external_store_overrides = st_reg.internal_flags[swcmd_pkg::BIT_EXT_OVERRIDE];
  assign eeprom_write             = st_reg.eeprom_wr;
  assign fram_write               = st_reg.fram_wr;
endmodule : swcmd_top

// File: verification/swcmd_host_model.sv
// Host model that sends command frames and takes answer bytes
module swcmd_host_model (
  // Clock and flow control
  input  wire logic       pclk,
  input  wire logic       stall,
  // Command link
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // Stalls at random so answer bytes must be held
  assign tx_ready = !stall;
  // One byte per cycle; between frames the data line toggles
  task automatic send(input logic [7:0] fr[48], input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= fr[i];
      rx_last <= (i == len - 1);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~fr[len-1];
  endtask : send
endmodule : swcmd_host_model

// File: verification/swcmd_sva.sv
// Port assertions for the settings write command handler
module swcmd_sva #(
  parameter int MS_CYCLES = 200
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Command link
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  // Motor side
  input wire logic        stop_state,
  input wire logic [7:0]  current_pct,
  input wire logic        motor_power_on,
  input wire logic        external_store_overrides,
  input wire logic        eeprom_write,
  input wire logic        fram_write
);
  logic last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_q <= 1'b0;
    else last_q <= rx_valid && rx_last;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  a_apb_one_wait: assert property (s_access |=> s_answer) else $error("apb answer late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data leaks");
  a_answer_cause: assert property ($rose(tx_valid) |-> last_q && tx_data == 8'h73)
    else $error("answer without frame");
  a_answer_hold: assert property (tx_valid && !tx_ready && !(rx_valid && rx_last)
    |=> tx_valid && $stable(tx_data)) else $error("answer byte dropped");
  a_store_pulse: assert property (eeprom_write |=> !eeprom_write) else $error("long pulse");
  a_store_echo: assert property (eeprom_write || fram_write |-> tx_valid)
    else $error("store without answer");
  a_pct_range: assert property (current_pct <= 8'h64) else $error("current over nominal");
  a_power_back: assert property (!stop_state ##1 !stop_state |=> motor_power_on)
    else $error("power off");
  a_override_src: assert property ($changed(external_store_overrides) |-> fram_write)
    else $error("override changed alone");
endmodule : swcmd_sva
bind swcmd_top swcmd_sva #(.MS_CYCLES(MS_CYCLES)) sva_u (.pclk, .presetn, .psel, .penable,
  .pready, .prdata, .pslverr, .rx_valid, .rx_last, .tx_valid, .tx_data, .tx_ready, .stop_state,
  .current_pct, .motor_power_on, .external_store_overrides, .eeprom_write, .fram_write);

// File: verification/tb_settings_write_command_handler.sv
// Self-checking testbench for the settings write command handler
module tb_settings_write_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, rx_valid, rx_last, tx_valid, tx_ready;
  logic        pready, pslverr, stall, stop_state, motor_power_on, external_store_overrides;
  logic        eeprom_write, fram_write;
  logic [7:0]  paddr, rx_data, tx_data, current_pct;
  logic [31:0] pwdata, prdata, keep;
  logic [31:0] seed = 32'd54169;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [32:0] rd_q[$];
  logic [7:0]  tx_q[$];
  logic [7:0]  fr[48];
  always #2.5 pclk = ~pclk;
  swcmd_top #(.MS_CYCLES(200)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data,
    .tx_ready, .stop_state, .current_pct, .motor_power_on, .external_store_overrides,
    .eeprom_write, .fram_write);
  swcmd_host_model host_u (.pclk, .stall, .rx_valid, .rx_data, .rx_last, .tx_ready);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rd_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 50 && !pready; i++) @(posedge pclk);
    if (!pready) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mk(input logic [31:0] c);
    for (int i = 0; i < 48; i++) fr[i] = 8'(rnd());
    for (int i = 0; i < 4; i++) fr[i] = c[8*i+:8];
  endtask : mk
  // Closes the frame with its byte sum; an answer is noted when one is due
  task automatic go(input int len, input logic ok, input logic ans);
    logic [15:0] s;
    s = 16'h0;
    for (int i = 4; i < len - 2; i++) s += 16'(fr[i]);
    if (!ok) s = ~s;
    fr[len-2] = s[7:0];
    fr[len-1] = s[15:8];
    if (ans) for (int i = 0; i < 4; i++) tx_q.push_back(fr[i]);
    host_u.send(fr, len);
    for (int i = 0; i < 200 && tx_q.size() > 0; i++) @(posedge pclk);
    if (tx_q.size() > 0) n_mismatch++;
    repeat (8) @(posedge pclk);
  endtask : go
  always @(posedge pclk) begin
    stall <= (rnd() % 3) == 0;
    if (psel && penable && pready && !pwrite) check("apb read", {pslverr, prdata},
      rd_q.size() > 0 ? rd_q.pop_front() : 33'bx);
    if (tx_valid && tx_ready) check("tx byte", 33'(tx_data),
      tx_q.size() > 0 ? 33'(tx_q.pop_front()) : 33'bx);
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, stall, stop_state} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("pct", 33'(current_pct), 33'h64);
    apb(1'b0, swcmd_pkg::ADDR_CTRL, 32'h0, {1'b0, swcmd_pkg::CTRL_RESET});
    apb(1'b0, 8'h30, 32'h0, 33'h100000000);
    mk(swcmd_pkg::CODE_STAGE_LABEL);
    go(30, 1'b1, 1'b1);
    apb(1'b0, swcmd_pkg::ADDR_STAGE, 32'h0, {1'b0, fr[7], fr[6], fr[5], fr[4]});
    mk(swcmd_pkg::CODE_UNIT_LABEL);
    fr[20] = 8'h01;
    go(30, 1'b1, 1'b1);
    check("override", 33'(external_store_overrides), 33'h1);
    apb(1'b0, swcmd_pkg::ADDR_FLAGS, 32'h0, 33'h1);
    mk(swcmd_pkg::CODE_USER_WORDS);
    go(36, 1'b1, 1'b1);
    apb(1'b0, 8'h64, 32'h0, {1'b0, fr[11], fr[10], fr[9], fr[8]});
    mk(swcmd_pkg::CODE_SECRET);
    go(36, 1'b1, 1'b1);
    apb(1'b0, swcmd_pkg::ADDR_SECRET, 32'h0, {1'b0, fr[7], fr[6], fr[5], fr[4]});
    mk(swcmd_pkg::CODE_PID);
    go(48, 1'b1, 1'b1);
    keep = {fr[7], fr[6], fr[5], fr[4]};
    mk(swcmd_pkg::CODE_PID);
    go(48, 1'b0, 1'b0);
    apb(1'b0, swcmd_pkg::ADDR_VGAIN_PI, 32'h0, {1'b0, keep});
    mk(swcmd_pkg::CODE_POWER);
    go(21, 1'b1, 1'b0);
    apb(1'b1, swcmd_pkg::ADDR_CTRL, 32'h0, 33'h0);
    go(20, 1'b1, 1'b0);
    apb(1'b1, swcmd_pkg::ADDR_CTRL, 32'h1, 33'h0);
    fr[4] = 8'h1e;
    {fr[6], fr[5], fr[8], fr[7], fr[11]} = {16'h0002, 16'h0000, 8'h03};
    go(20, 1'b1, 1'b1);
    apb(1'b0, swcmd_pkg::ADDR_POWER, 32'h0, 33'h031e);
    apb(1'b0, swcmd_pkg::ADDR_DELAYS, 32'h0, 33'h2);
    stop_state <= 1'b1;
    repeat (200) @(posedge pclk);
    check("early pct", 33'(current_pct), 33'h64);
    repeat (250) @(posedge pclk);
    check("hold pct", 33'(current_pct), 33'h1e);
    check("power off", 33'(motor_power_on), 33'h0);
    stop_state <= 1'b0;
    repeat (3) @(posedge pclk);
    check("moving pct", 33'(current_pct), 33'h64);
    finish_test();
  end
endmodule : tb_settings_write_command_handler
